// [rtl/dpsm_pkg.sv]
// Package: constants and types for the drive power state machine
package dpsm_pkg;

  // Command word bit positions
  localparam int unsigned CW_SWITCH_ON   = 0;
  localparam int unsigned CW_EN_VOLTAGE  = 1;
  localparam int unsigned CW_QUICK_STOP  = 2;
  localparam int unsigned CW_EN_OPER     = 3;
  localparam int unsigned CW_FAULT_RESET = 7;
  localparam int unsigned CW_HALT        = 8;

  // State word bit positions
  localparam int unsigned SW_READY       = 0;
  localparam int unsigned SW_SWITCHED_ON = 1;
  localparam int unsigned SW_OPER_EN     = 2;
  localparam int unsigned SW_FAULT       = 3;
  localparam int unsigned SW_VOLTAGE     = 4;
  localparam int unsigned SW_QUICK_STOP  = 5;
  localparam int unsigned SW_SO_DISABLED = 6;
  localparam int unsigned SW_HALT        = 8;

  // Register indices
  localparam logic [3:0] ADDR_CTRL   = 4'h0;
  localparam logic [3:0] ADDR_STATUS = 4'h1;
  localparam logic [3:0] ADDR_MODE   = 4'h2;
  localparam logic [3:0] ADDR_QSOPT  = 4'h3;
  localparam logic [3:0] ADDR_STATE  = 4'h4;

  localparam logic [15:0] CTRL_RST  = 16'h0000;
  localparam logic [2:0]  QSOPT_RST = 3'h2;
  localparam logic [2:0]  QSOPT_STAY = 3'h5;
  localparam logic [7:0]  MODE_RST  = 8'h00;

  // Operating modes
  localparam logic [7:0] MODE_PROF_POS = 8'h01;
  localparam logic [7:0] MODE_PROF_VEL = 8'h03;
  localparam logic [7:0] MODE_PROF_TRQ = 8'h04;
  localparam logic [7:0] MODE_HOMING   = 8'h06;
  localparam logic [7:0] MODE_INTERP   = 8'h07;

  // Gray-coded along init -> disabled -> ready -> on -> enabled
  typedef enum logic [2:0] {
    DPSM_NOT_READY = 3'h0,
    DPSM_SO_DIS    = 3'h1,
    DPSM_READY     = 3'h3,
    DPSM_ON        = 3'h2,
    DPSM_OP_EN     = 3'h6,
    DPSM_QSTOP     = 3'h7,
    DPSM_FLT_REACT = 3'h5,
    DPSM_FAULT     = 3'h4
  } dpsm_state_t;

  typedef enum logic [2:0] {
    DPSM_CMD_NONE,
    DPSM_CMD_SHUTDOWN,
    DPSM_CMD_SWITCH_ON,
    DPSM_CMD_ENABLE_OP,
    DPSM_CMD_DISABLE_OP,
    DPSM_CMD_DISABLE_V,
    DPSM_CMD_QUICK_STOP,
    DPSM_CMD_FAULT_RST
  } dpsm_cmd_t;

  typedef struct packed {
    logic brake_release;
    logic power_on;
    logic drive_en;
    logic qstop_run;
    logic fault_react_run;
    logic param_write_ok;
  } dpsm_drive_t;

  typedef struct packed {
    dpsm_state_t state;
    logic [15:0] ctrl;
    logic        fault_rst_prev;
    logic [7:0]  mode;
    logic [2:0]  qsopt;
    logic        fault_latched;
    logic [15:0] rdata;
  } dpsm_regs_t;

endpackage

// [rtl/dpsm_decode.sv]
// Command decoder: control word plus fault-reset edge into one command
`timescale 1ns/100ps
`default_nettype none

module dpsm_decode (
  input  wire logic [15:0]        ctrl,
  input  wire logic               fault_rst_prev,
  output dpsm_pkg::dpsm_cmd_t     cmd
);

  logic so;
  logic ev;
  logic qs;
  logic eo;
  logic fr;

  always_comb begin
    so = ctrl[dpsm_pkg::CW_SWITCH_ON];
    ev = ctrl[dpsm_pkg::CW_EN_VOLTAGE];
    qs = ctrl[dpsm_pkg::CW_QUICK_STOP];
    eo = ctrl[dpsm_pkg::CW_EN_OPER];
    fr = ctrl[dpsm_pkg::CW_FAULT_RESET];
    // Fault reset edge wins over all other encodings
    if (fr && !fault_rst_prev) begin
      cmd = dpsm_pkg::DPSM_CMD_FAULT_RST;
    end else if (!ev) begin
      cmd = dpsm_pkg::DPSM_CMD_DISABLE_V;
    end else if (!qs) begin
      cmd = dpsm_pkg::DPSM_CMD_QUICK_STOP;
    end else if (!so) begin
      cmd = dpsm_pkg::DPSM_CMD_SHUTDOWN;
    end else if (eo) begin
      cmd = dpsm_pkg::DPSM_CMD_ENABLE_OP;
    end else begin
      // Switch on and disable operation share one code; state picks meaning
      cmd = dpsm_pkg::DPSM_CMD_SWITCH_ON;
    end
  end

endmodule

`default_nettype wire

// [rtl/dpsm_top.sv]
// Drive power state machine with a small register port
// How it works
// - Reset enters not-ready state; self-test runs there before anything else.
// - Not-ready keeps brake applied and drive function disabled.
// - Self-test success moves to switch-on-disabled and starts monitoring.
// - Shutdown goes to ready from disabled, switched-on and enabled; power off.
// - Switch-on in ready goes to switched-on and energises power.
// - Enable-operation in switched-on goes to enabled, drive function on.
// - Disable-operation in enabled returns to switched-on, drive off.
// - Quick stop in ready goes to switch-on-disabled.
// - Disable-voltage from enabled/on, quick stop from on: disabled, power cut.
// - Quick stop in enabled enters quick-stop-active.
// - Quick stop done or disable-voltage leaves quick stop unless option is 5.
// - With option 5 stay in quick stop; only enable-operation or a fault exits.
// - Fault detected enters fault-reaction-active.
// - Fault reaction done enters fault; drive off, power may go off.
// - Fault reset in fault goes to disabled only if no fault present.
// - Fault reaction keeps drive on and power applied during quick stop.
// - Parameter writes allowed in every state but not-ready.
// - Drive only in enabled, quick stop, fault reaction; motor power in those and in switched-on.
// - State machine runs only while the network is operational; register port always works.
// - Homing, position, velocity, torque, interpolated modes selectable.
// - Commands without a transition from the current state are ignored.
// - Switched-on has voltage and power stage ready, drive function off.
// - Rising edge of bit 7 clears faults; host clears bit afterwards.
// - State word reports ready, on, enabled, fault, quick stop, disabled.
`timescale 1ns/100ps
`default_nettype none

module dpsm_top (
  input  wire logic               clk,
  input  wire logic               nrst,
  input  wire logic [3:0]         addr,
  input  wire logic [15:0]        wdata,
  input  wire logic               wr,
  input  wire logic               rd,
  output logic [15:0]             rdata,
  input  wire logic               net_operational,
  input  wire logic               selftest_done,
  input  wire logic               selftest_ok,
  input  wire logic               fault_present,
  input  wire logic               fault_react_done,
  input  wire logic               qstop_done,
  input  wire logic               bus_voltage_ok,
  output logic                    param_write_ok,
  output logic                    power_on,
  output logic                    drive_en,
  output logic                    brake_release,
  output logic                    qstop_run,
  output logic                    fault_react_run,
  output logic                    halt_req,
  output logic [7:0]              operating_mode_select,
  output logic [15:0]             state_word
);

  dpsm_pkg::dpsm_regs_t  r_q;
  dpsm_pkg::dpsm_regs_t  r_d;
  dpsm_pkg::dpsm_cmd_t   cmd;
  dpsm_pkg::dpsm_drive_t drv;
  logic [15:0]           sw;

  ////////////////////////////////////////////////////////////////////////////////
  // Helpers

  function automatic logic mode_valid(input logic [7:0] m);
    mode_valid = (m == dpsm_pkg::MODE_PROF_POS) || (m == dpsm_pkg::MODE_PROF_VEL) ||
                 (m == dpsm_pkg::MODE_PROF_TRQ) || (m == dpsm_pkg::MODE_HOMING) ||
                 (m == dpsm_pkg::MODE_INTERP);
  endfunction

  function automatic dpsm_pkg::dpsm_drive_t drive_of(input dpsm_pkg::dpsm_state_t s);
    dpsm_pkg::dpsm_drive_t d;
    d = '0;
    d.param_write_ok = (s != dpsm_pkg::DPSM_NOT_READY);
    case (s)
      dpsm_pkg::DPSM_NOT_READY: begin
        d.param_write_ok = 1'b0;
      end
      dpsm_pkg::DPSM_ON: begin
        d.power_on = 1'b1;
      end
      dpsm_pkg::DPSM_OP_EN: begin
        d.power_on      = 1'b1;
        d.drive_en      = 1'b1;
        d.brake_release = 1'b1;
      end
      dpsm_pkg::DPSM_QSTOP: begin
        d.power_on      = 1'b1;
        d.drive_en      = 1'b1;
        d.brake_release = 1'b1;
        d.qstop_run     = 1'b1;
      end
      dpsm_pkg::DPSM_FLT_REACT: begin
        d.power_on        = 1'b1;
        d.drive_en        = 1'b1;
        d.brake_release   = 1'b1;
        d.qstop_run       = 1'b1;
        d.fault_react_run = 1'b1;
      end
      dpsm_pkg::DPSM_SO_DIS: begin
        d.power_on = 1'b0;
      end
      dpsm_pkg::DPSM_READY: begin
        d.power_on = 1'b0;
      end
      dpsm_pkg::DPSM_FAULT: begin
        // Power could stay up in fault; cutting it keeps a faulted stage safe
        d.power_on = 1'b0;
      end
      default: begin
        d.power_on = 1'b0;
      end
    endcase
    drive_of = d;
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  // Command decode

  dpsm_decode u_decode (
    .ctrl           (r_q.ctrl),
    .fault_rst_prev (r_q.fault_rst_prev),
    .cmd            (cmd)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // Next state

  always_comb begin
    r_d = r_q;
    if (net_operational) begin
      r_d.fault_rst_prev = r_q.ctrl[dpsm_pkg::CW_FAULT_RESET];
      if (fault_present) begin
        r_d.fault_latched = 1'b1;
      end
      // Fault first, except during init and while already handling one
      if (fault_present && (r_q.state != dpsm_pkg::DPSM_NOT_READY) &&
          (r_q.state != dpsm_pkg::DPSM_FLT_REACT) &&
          (r_q.state != dpsm_pkg::DPSM_FAULT)) begin
        r_d.state = dpsm_pkg::DPSM_FLT_REACT;
      end else begin
        // Unlisted command/state pairs fall through unchanged
        case (r_q.state)
          dpsm_pkg::DPSM_NOT_READY: begin
            if (selftest_done && selftest_ok) begin
              r_d.state = dpsm_pkg::DPSM_SO_DIS;
            end
          end
          dpsm_pkg::DPSM_SO_DIS: begin
            if (cmd == dpsm_pkg::DPSM_CMD_SHUTDOWN) begin
              r_d.state = dpsm_pkg::DPSM_READY;
            end
          end
          dpsm_pkg::DPSM_READY: begin
            if (cmd == dpsm_pkg::DPSM_CMD_SWITCH_ON ||
                cmd == dpsm_pkg::DPSM_CMD_ENABLE_OP) begin
              r_d.state = dpsm_pkg::DPSM_ON;
            end else if (cmd == dpsm_pkg::DPSM_CMD_QUICK_STOP ||
                         cmd == dpsm_pkg::DPSM_CMD_DISABLE_V) begin
              r_d.state = dpsm_pkg::DPSM_SO_DIS;
            end
          end
          dpsm_pkg::DPSM_ON: begin
            if (cmd == dpsm_pkg::DPSM_CMD_ENABLE_OP) begin
              r_d.state = dpsm_pkg::DPSM_OP_EN;
            end else if (cmd == dpsm_pkg::DPSM_CMD_SHUTDOWN) begin
              r_d.state = dpsm_pkg::DPSM_READY;
            end else if (cmd == dpsm_pkg::DPSM_CMD_DISABLE_V ||
                         cmd == dpsm_pkg::DPSM_CMD_QUICK_STOP) begin
              r_d.state = dpsm_pkg::DPSM_SO_DIS;
            end
          end
          dpsm_pkg::DPSM_OP_EN: begin
            if (cmd == dpsm_pkg::DPSM_CMD_SWITCH_ON) begin
              r_d.state = dpsm_pkg::DPSM_ON;
            end else if (cmd == dpsm_pkg::DPSM_CMD_SHUTDOWN) begin
              r_d.state = dpsm_pkg::DPSM_READY;
            end else if (cmd == dpsm_pkg::DPSM_CMD_DISABLE_V) begin
              r_d.state = dpsm_pkg::DPSM_SO_DIS;
            end else if (cmd == dpsm_pkg::DPSM_CMD_QUICK_STOP) begin
              r_d.state = dpsm_pkg::DPSM_QSTOP;
            end
          end
          dpsm_pkg::DPSM_QSTOP: begin
            if (r_q.qsopt == dpsm_pkg::QSOPT_STAY) begin
              if (cmd == dpsm_pkg::DPSM_CMD_ENABLE_OP) begin
                r_d.state = dpsm_pkg::DPSM_OP_EN;
              end
            end else if (qstop_done || cmd == dpsm_pkg::DPSM_CMD_DISABLE_V) begin
              r_d.state = dpsm_pkg::DPSM_SO_DIS;
            end
          end
          dpsm_pkg::DPSM_FLT_REACT: begin
            if (fault_react_done) begin
              r_d.state = dpsm_pkg::DPSM_FAULT;
            end
          end
          dpsm_pkg::DPSM_FAULT: begin
            // A fault still present keeps the latch; the reset is refused
            if (cmd == dpsm_pkg::DPSM_CMD_FAULT_RST && !fault_present) begin
              r_d.state         = dpsm_pkg::DPSM_SO_DIS;
              r_d.fault_latched = 1'b0;
            end
          end
          default: begin
            r_d.state = dpsm_pkg::DPSM_NOT_READY;
          end
        endcase
      end
    end
    // Register writes; mode and option are parameters, locked during init
    if (wr) begin
      case (addr)
        dpsm_pkg::ADDR_CTRL: begin
          r_d.ctrl = wdata;
        end
        dpsm_pkg::ADDR_MODE: begin
          if (drv.param_write_ok && mode_valid(wdata[7:0])) begin
            r_d.mode = wdata[7:0];
          end
        end
        dpsm_pkg::ADDR_QSOPT: begin
          if (drv.param_write_ok) begin
            r_d.qsopt = wdata[2:0];
          end
        end
        default: begin
          // Status and raw state are read only; writes there are dropped
        end
      endcase
    end
    // Read data valid only in the cycle after the strobe
    r_d.rdata = 16'h0000;
    if (rd) begin
      case (addr)
        dpsm_pkg::ADDR_CTRL: begin
          r_d.rdata = r_q.ctrl;
        end
        dpsm_pkg::ADDR_STATUS: begin
          r_d.rdata = sw;
        end
        dpsm_pkg::ADDR_MODE: begin
          r_d.rdata = {8'h00, r_q.mode};
        end
        dpsm_pkg::ADDR_QSOPT: begin
          r_d.rdata = {13'h0000, r_q.qsopt};
        end
        dpsm_pkg::ADDR_STATE: begin
          r_d.rdata = {13'h0000, r_q.state};
        end
        // Unmapped indices read zero
        default: begin
          r_d.rdata = 16'h0000;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Outputs and state word

  always_comb begin
    drv = drive_of(r_q.state);
    sw  = 16'h0000;
    // One flag pattern per state, fault reaction and fault sharing one; the quick stop flag is active low
    case (r_q.state)
      dpsm_pkg::DPSM_NOT_READY: begin
        sw[dpsm_pkg::SW_QUICK_STOP] = 1'b1;
      end
      dpsm_pkg::DPSM_SO_DIS: begin
        sw[dpsm_pkg::SW_QUICK_STOP]  = 1'b1;
        sw[dpsm_pkg::SW_SO_DISABLED] = 1'b1;
      end
      dpsm_pkg::DPSM_READY: begin
        sw[dpsm_pkg::SW_READY]      = 1'b1;
        sw[dpsm_pkg::SW_QUICK_STOP] = 1'b1;
      end
      dpsm_pkg::DPSM_ON: begin
        sw[dpsm_pkg::SW_READY]       = 1'b1;
        sw[dpsm_pkg::SW_SWITCHED_ON] = 1'b1;
        sw[dpsm_pkg::SW_QUICK_STOP]  = 1'b1;
      end
      dpsm_pkg::DPSM_OP_EN: begin
        sw[dpsm_pkg::SW_READY]       = 1'b1;
        sw[dpsm_pkg::SW_SWITCHED_ON] = 1'b1;
        sw[dpsm_pkg::SW_OPER_EN]     = 1'b1;
        sw[dpsm_pkg::SW_QUICK_STOP]  = 1'b1;
      end
      dpsm_pkg::DPSM_QSTOP: begin
        // Quick stop flag left low: the host reads it as a stop in progress
        sw[dpsm_pkg::SW_READY]       = 1'b1;
        sw[dpsm_pkg::SW_SWITCHED_ON] = 1'b1;
        sw[dpsm_pkg::SW_OPER_EN]     = 1'b1;
      end
      dpsm_pkg::DPSM_FLT_REACT: begin
        sw[dpsm_pkg::SW_FAULT]      = 1'b1;
        sw[dpsm_pkg::SW_QUICK_STOP] = 1'b1;
      end
      dpsm_pkg::DPSM_FAULT: begin
        sw[dpsm_pkg::SW_FAULT]      = 1'b1;
        sw[dpsm_pkg::SW_QUICK_STOP] = 1'b1;
      end
      default: begin
        sw = 16'h0000;
      end
    endcase
    sw[dpsm_pkg::SW_FAULT]   = sw[dpsm_pkg::SW_FAULT] || r_q.fault_latched;
    sw[dpsm_pkg::SW_VOLTAGE] = bus_voltage_ok;
    sw[dpsm_pkg::SW_HALT]    = r_q.ctrl[dpsm_pkg::CW_HALT];
  end

  assign param_write_ok        = drv.param_write_ok;
  assign power_on              = drv.power_on;
  assign drive_en              = drv.drive_en;
  assign brake_release         = drv.brake_release;
  assign qstop_run             = drv.qstop_run;
  assign fault_react_run       = drv.fault_react_run;
  assign halt_req              = r_q.ctrl[dpsm_pkg::CW_HALT] && drv.drive_en;
  assign operating_mode_select = r_q.mode;
  assign state_word            = sw;
  assign rdata                 = r_q.rdata;

  ////////////////////////////////////////////////////////////////////////////////
  // State register

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      r_q.state          <= dpsm_pkg::DPSM_NOT_READY;
      r_q.ctrl           <= dpsm_pkg::CTRL_RST;
      r_q.fault_rst_prev <= 1'b0;
      r_q.mode           <= dpsm_pkg::MODE_RST;
      r_q.qsopt          <= dpsm_pkg::QSOPT_RST;
      r_q.fault_latched  <= 1'b0;
      r_q.rdata          <= 16'h0000;
    end else begin
      r_q <= r_d;
    end
  end

endmodule

`default_nettype wire

// [sim/dpsm_checker.sv]
// Checker: port-level assertions for the drive power state machine
`timescale 1ns/100ps
`default_nettype none

module dpsm_checker (
  input wire logic        clk,
  input wire logic        nrst,
  input wire logic [3:0]  addr,
  input wire logic        rd,
  input wire logic [15:0] rdata,
  input wire logic        net_operational,
  input wire logic        fault_present,
  input wire logic        param_write_ok,
  input wire logic        power_on,
  input wire logic        drive_en,
  input wire logic        brake_release,
  input wire logic        qstop_run,
  input wire logic        fault_react_run,
  input wire logic [7:0]  operating_mode_select,
  input wire logic [15:0] state_word
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!nrst);

  chk_nrdy_safe: assert property (!param_write_ok |-> !brake_release && !drive_en && !power_on)
    else $error("not-ready state drives the motor");
  chk_drive_gate: assert property (drive_en |-> state_word[2] || fault_react_run)
    else $error("drive enabled in a stopped state");
  chk_react_power: assert property (fault_react_run |-> drive_en && power_on)
    else $error("fault reaction without motor power");
  chk_on_nodrive: assert property (state_word[3:0] == 4'h3 |-> power_on && !drive_en)
    else $error("switched-on state has wrong power outputs");
  chk_param_gate: assert property (param_write_ok == (|{state_word[6], state_word[3:0]}))
    else $error("parameter permission disagrees with state");
  chk_dis_off: assert property (state_word[6] |-> !power_on && !drive_en)
    else $error("power left on in switch-on-disabled");
  // A stalled network freezes state flags from the next edge on
  chk_net_freeze: assert property (!net_operational |=> $stable(state_word[2:0]) && $stable(state_word[6]))
    else $error("state moved while network not operational");
  chk_fault_first: assert property (net_operational && fault_present && param_write_ok &&
                                    !fault_react_run && !state_word[3] |=> fault_react_run)
    else $error("fault did not force fault reaction");
  chk_qs_flag: assert property (qstop_run && !fault_react_run |->
                                !state_word[5] && state_word[2:0] == 3'h7)
    else $error("quick stop flags wrong");
  chk_react_flag: assert property (fault_react_run |-> state_word[3])
    else $error("fault reaction without fault flag");
  chk_mode_read: assert property (rd && addr == dpsm_pkg::ADDR_MODE |=>
                                  rdata == {8'h00, $past(operating_mode_select)})
    else $error("mode read back differs");
endmodule

bind dpsm_top dpsm_checker dpsm_checker_i (.clk, .nrst, .addr, .rd, .rdata, .net_operational,
  .fault_present, .param_write_ok, .power_on, .drive_en, .brake_release, .qstop_run,
  .fault_react_run, .operating_mode_select, .state_word);
`default_nettype wire

// [sim/dpsm_plant.sv]
// Power stage and motion model: self-test, quick stop and fault reaction completion
`timescale 1ns/100ps
`default_nettype none

module dpsm_plant (
  input wire logic       clk,
  input wire logic       nrst,
  input wire logic       qstop_run,
  input wire logic       fault_react_run,
  input wire logic       power_on,
  input wire logic       hold,
  input wire logic [7:0] dly,
  output logic           selftest_done,
  output logic           selftest_ok,
  output logic           qstop_done,
  output logic           fault_react_done,
  output logic           bus_voltage_ok
);
  logic [7:0] cnt_q;
  logic [2:0] st_q;

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      cnt_q <= 8'h00;
      st_q  <= 3'h0;
    end else begin
      if (st_q != 3'h7) begin
        st_q <= st_q + 3'h1;
      end
      // Stop time counts only while a stop runs; hold stands for a slow stop
      if ((qstop_run || fault_react_run) && cnt_q != 8'hff) begin
        cnt_q <= cnt_q + 8'h01;
      end else if (!(qstop_run || fault_react_run)) begin
        cnt_q <= 8'h00;
      end
    end
  end

  assign selftest_done    = (st_q == 3'h7);
  assign selftest_ok      = 1'b1;
  assign qstop_done       = qstop_run && !hold && (cnt_q >= dly);
  assign fault_react_done = fault_react_run && !hold && (cnt_q >= dly);
  assign bus_voltage_ok   = power_on;
endmodule
`default_nettype wire

// [sim/testbench.sv]
// Self-checking testbench for the drive power state machine
`timescale 1ns/100ps
`default_nettype none

module testbench;
  logic        clk, nrst, wr, rd, net_operational, fault_present, plant_hold;
  logic [3:0]  addr;
  logic [15:0] wdata, rdata, state_word, v;
  logic        selftest_done, selftest_ok, fault_react_done, qstop_done, bus_voltage_ok;
  logic        param_write_ok, power_on, drive_en, brake_release, qstop_run, fault_react_run;
  logic        halt_req;
  logic [7:0]  operating_mode_select, plant_dly;
  int          mismatches, n_compared;

  dpsm_top dpsm_top_i (.clk, .nrst, .addr, .wdata, .wr, .rd, .rdata, .net_operational,
    .selftest_done, .selftest_ok, .fault_present, .fault_react_done, .qstop_done,
    .bus_voltage_ok, .param_write_ok, .power_on, .drive_en, .brake_release, .qstop_run,
    .fault_react_run, .halt_req, .operating_mode_select, .state_word);
  dpsm_plant dpsm_plant_i (.clk, .nrst, .qstop_run, .fault_react_run, .power_on,
    .hold(plant_hold), .dly(plant_dly), .selftest_done, .selftest_ok, .qstop_done,
    .fault_react_done, .bus_voltage_ok);

  ////////////////////////////////////////////////////////////////////////////////
  task automatic give_verdict;
    if (mismatches == 0 && n_compared > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  task automatic cmp(input string nm, input logic [15:0] e, input logic [15:0] g);
    n_compared++;
    if (g !== e) begin
      mismatches++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic wr_reg(input logic [3:0] a, input logic [15:0] d);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
    @(posedge clk);
  endtask

  task automatic rd_reg(input logic [3:0] a, output logic [15:0] d);
    addr <= a;
    rd   <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 d = rdata;
    @(posedge clk);
  endtask

  // Flags other than voltage and halt, so the check ignores the plant's supply
  task automatic st(input logic [15:0] e);
    #1 cmp("state_word", e, state_word & 16'h006f);
  endtask

  task automatic cmd(input logic [15:0] d);
    wr_reg(dpsm_pkg::ADDR_CTRL, d);
    repeat (3) @(posedge clk);
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  task automatic t_reset;
    st(16'h0020);
    cmp("brake_release", 16'h0000, {15'h0, brake_release});
    wr_reg(dpsm_pkg::ADDR_MODE, 16'h0003);
    rd_reg(dpsm_pkg::ADDR_MODE, v);
    cmp("mode", 16'h0000, v);
    rd_reg(dpsm_pkg::ADDR_QSOPT, v);
    cmp("qsopt", 16'h0002, v);
    repeat (10) @(posedge clk);
    st(16'h0060);
  endtask

  task automatic t_path;
    cmd(16'h000f);
    st(16'h0060);
    cmd(16'h0006);
    st(16'h0021);
    cmd(16'h0007);
    st(16'h0023);
    cmp("power_on", 16'h0001, {15'h0, power_on});
    cmd(16'h010f);
    st(16'h0027);
    cmp("halt_req", 16'h0001, {15'h0, halt_req});
    cmp("brake_release", 16'h0001, {15'h0, brake_release});
    cmp("state_word_hi", 16'h0110, state_word & 16'h0110);
    rd_reg(dpsm_pkg::ADDR_STATUS, v);
    cmp("status_read", 16'h0137, v);
    rd_reg(dpsm_pkg::ADDR_STATE, v);
    cmp("state_read", {13'h0000, dpsm_pkg::DPSM_OP_EN}, v);
    rd_reg(dpsm_pkg::ADDR_CTRL, v);
    cmp("ctrl_read", 16'h010f, v);
    cmd(16'h0007);
    st(16'h0023);
    cmd(16'h000f);
    cmd(16'h0006);
    st(16'h0021);
    cmd(16'h0007);
    cmd(16'h000b);
    st(16'h0060);
    cmd(16'h0006);
    cmd(16'h0002);
    st(16'h0060);
    net_operational <= 1'b0;
    cmd(16'h0006);
    st(16'h0060);
    net_operational <= 1'b1;
    repeat (3) @(posedge clk);
    st(16'h0021);
    cmd(16'h0007);
    cmd(16'h000f);
    cmd(16'h0000);
    st(16'h0060);
  endtask

  task automatic t_qstop;
    plant_dly <= 8'd20;
    cmd(16'h0006);
    cmd(16'h0007);
    cmd(16'h000f);
    cmd(16'h000b);
    st(16'h0007);
    cmp("qstop_run", 16'h0001, {15'h0, qstop_run});
    repeat (25) @(posedge clk);
    st(16'h0060);
    wr_reg(dpsm_pkg::ADDR_QSOPT, 16'h0005);
    cmd(16'h0006);
    cmd(16'h0007);
    cmd(16'h000f);
    cmd(16'h000b);
    repeat (25) @(posedge clk);
    cmd(16'h0000);
    st(16'h0007);
    cmd(16'h000f);
    st(16'h0027);
    wr_reg(dpsm_pkg::ADDR_QSOPT, 16'h0002);
    plant_hold <= 1'b1;
    cmd(16'h000b);
    cmd(16'h0000);
    st(16'h0060);
  endtask

  task automatic t_fault;
    plant_dly <= 8'd2;
    cmd(16'h0006);
    cmd(16'h0007);
    cmd(16'h000f);
    fault_present <= 1'b1;
    repeat (3) @(posedge clk);
    #1 cmp("fault_react_run", 16'h0001, {15'h0, fault_react_run});
    cmp("drive_en", 16'h0001, {15'h0, drive_en});
    plant_hold <= 1'b0;
    repeat (6) @(posedge clk);
    #1 cmp("fault_state", 16'h0008, state_word & 16'h004f);
    cmp("drive_en", 16'h0000, {15'h0, drive_en});
    cmd(16'h008f);
    #1 cmp("fault_state", 16'h0008, state_word & 16'h004f);
    fault_present <= 1'b0;
    cmd(16'h000f);
    cmd(16'h008f);
    st(16'h0060);
    cmd(16'h0000);
  endtask

  task automatic t_modes;
    logic [7:0] codes [5];
    codes = '{dpsm_pkg::MODE_PROF_POS, dpsm_pkg::MODE_PROF_VEL, dpsm_pkg::MODE_PROF_TRQ,
              dpsm_pkg::MODE_HOMING, dpsm_pkg::MODE_INTERP};
    for (int i = 0; i < 5; i++) begin
      wr_reg(dpsm_pkg::ADDR_MODE, {8'h00, codes[i]});
      rd_reg(dpsm_pkg::ADDR_MODE, v);
      cmp("mode", {8'h00, codes[i]}, v);
      cmp("mode_out", {8'h00, codes[i]}, {8'h00, operating_mode_select});
    end
    wr_reg(dpsm_pkg::ADDR_MODE, 16'h0002);
    rd_reg(dpsm_pkg::ADDR_MODE, v);
    cmp("mode", {8'h00, dpsm_pkg::MODE_INTERP}, v);
    rd_reg(4'h9, v);
    cmp("unmapped", 16'h0000, v);
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // Whole run is well under a thousand cycles
  initial begin
    repeat (5000) @(posedge clk);
    mismatches++;
    give_verdict();
  end

  initial begin
    mismatches = 0;
    n_compared = 0;
    nrst = 1'b0;
    wr = 1'b0;
    rd = 1'b0;
    addr = 4'h0;
    wdata = 16'h0000;
    net_operational = 1'b1;
    fault_present = 1'b0;
    plant_hold = 1'b0;
    plant_dly = 8'd4;
    repeat (12) @(posedge clk);
    nrst <= 1'b1;
    @(posedge clk);
    t_reset();
    t_path();
    t_qstop();
    t_fault();
    t_modes();
    give_verdict();
  end
endmodule
`default_nettype wire
